// file: hw/mscr_pkg.sv
// mscr_pkg: constants and types for the mode, sleep and restart control block
package mscr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MSCR_MODE_ONE_ADDR  = 8'h00;
  localparam logic [7:0] MSCR_MODE_TWO_ADDR  = 8'h01;
  localparam logic [7:0] MSCR_PWM_FIRST_ADDR = 8'h06;
  localparam logic [7:0] MSCR_PWM_LAST_ADDR  = 8'h45;
  localparam logic [7:0] MSCR_GLB_FIRST_ADDR = 8'hFA;
  localparam logic [7:0] MSCR_GLB_LAST_ADDR  = 8'hFD;
  localparam logic [7:0] MSCR_PTR_STEP       = 8'h01;
  localparam logic [7:0] MSCR_READ_ZERO      = 8'h00;

  // ----------------------------------------------------------------
  // mode_control_one fields
  // ----------------------------------------------------------------
  localparam int MSCR_RESTART_BIT = 7;
  localparam int MSCR_EXTERNAL_CLOCK_SELECT_BIT  = 6;
  localparam int MSCR_AUTOINC_BIT = 5;
  localparam int MSCR_SLEEP_BIT   = 4;
  localparam int MSCR_SECONDARY_ADDR_ONE_ENABLE_BIT    = 3;
  localparam int MSCR_SECONDARY_ADDR_TWO_ENABLE_BIT    = 2;
  localparam int MSCR_SECONDARY_ADDR_THREE_ENABLE_BIT    = 1;
  localparam int MSCR_BCAST_BIT   = 0;

  localparam logic [2:0] MSCR_SUB_RESET   = 3'h0;
  localparam logic       MSCR_SLEEP_RESET = 1'b1;
  localparam logic       MSCR_BCAST_RESET = 1'b1;

  // mode_control_two: low five bits stored, three high bits read zero
  localparam int         MSCR_OCH_BIT     = 3;
  localparam logic [4:0] MSCR_MODE_CONTROL_TWO_RESET = 5'h04;
  localparam logic [2:0] MSCR_MODE_CONTROL_TWO_PAD   = 3'h0;

  // ----------------------------------------------------------------
  // channels and timing
  // ----------------------------------------------------------------
  localparam int MSCR_CHANNELS     = 16;
  localparam int MSCR_REGS_PER_CH  = 4;
  localparam int MSCR_CLOCK_NS     = 100;
  localparam int MSCR_OSC_START_US = 500;
  localparam int MSCR_OSC_START_CYCLES =
    (MSCR_OSC_START_US * 1000 + MSCR_CLOCK_NS - 1) / MSCR_CLOCK_NS;
  localparam int MSCR_OSC_CNT_W = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSCR_RS_RUN   = 2'h0,
    MSCR_RS_DRAIN = 2'h1,
    MSCR_RS_SLEEP = 2'h3,
    MSCR_RS_WAKE  = 2'h2
  } mscr_rs_e;

  typedef struct packed {
    logic       ptr_load;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mscr_acc_s;

  typedef struct packed {
    logic [7:0]                                   ptr;
    logic                                         restart;
    logic                                         external_clock_select;
    logic                                         autoinc;
    logic                                         sleep;
    logic [2:0]                                   sub_en;
    logic                                         bcast_en;
    logic [4:0]                                   mode_control_two;
    mscr_rs_e                                     rs;
    logic [MSCR_OSC_CNT_W-1:0]                    osc_cnt;
    logic                                         osc_ready;
    logic                                         pwm_dirty;
    logic [MSCR_CHANNELS*MSCR_REGS_PER_CH-1:0]    ch_mask;
    logic [7:0]                                   rdata;
    logic                                         resume;
    logic                                         invalidate;
    logic                                         pwm_run;
    logic                                         hold;
    logic                                         osc_en;
  } mscr_state_s;

endpackage : mscr_pkg

// file: hw/mscr_mode_ctrl.sv
// mscr_mode_ctrl: mode register bank with sleep and restart sequencing
// Function
// [R1] auto-increment set: pointer advances after each access; clear (reset): stays
// [R2] sleep resets to 1, oscillator stopped; writing 0 gives normal mode
// [R3] three secondary address enables gate acknowledgement, all reset to 0
// [R4] broadcast address enable gates response, resets to 1
// [R5] oscillator needs up to 500 us after sleep clears; host waits
// [R6] external clock selected: no start-up wait on leaving sleep
// [R7] no pwm activity while oscillator is stopped in sleep; pwm_run stays set through drain although osc_en is already low
// [R8] sleep with active channels sets restart flag at period end
// [R9] channel register values held while clock stopped
// [R10] host confirms flag, clears sleep, waits 500 us, then writes restart
// [R11] restart write after wake resumes channels and clears the flag
// [R12] software reset and power-up clear the restart flag
// [R13] output-change 0: pwm write then bus stop clears the flag
// [R14] output-change 1: all four registers of one channel clear flag
// [R15] orderly shutdown before sleep leaves flag clear, contents invalid
// [R16] host reloads pwm registers after orderly shutdown
// [R17] flag reads state; write 1 clears, write 0 no effect, reset 0
// [R18] output-change bit: 0 at stop (reset), 1 at acknowledge
// [R19] restart write acts only when awake with a restart pending
`timescale 1ns/100ps
`default_nettype none

module mscr_mode_ctrl
  import mscr_pkg::*;
#(
  parameter int OSC_START_CYCLES = MSCR_OSC_START_CYCLES
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire mscr_acc_s  i_acc,
  input  wire logic       i_bus_stop,
  input  wire logic       i_soft_reset,
  input  wire logic       i_period_end,
  input  wire logic       i_channels_active,
  output logic [7:0]      o_pointer,
  output logic [7:0]      o_rdata,
  output logic [2:0]      o_sub_enable,
  output logic            o_broadcast_enable,
  output logic            o_osc_enable,
  output logic            o_osc_ready,
  output logic            o_pwm_run,
  output logic            o_channel_hold,
  output logic            o_apply_on_ack,
  output logic            o_resume,
  output logic            o_invalidate
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_chan_reg(input logic [7:0] a);
    return (a >= MSCR_PWM_FIRST_ADDR) && (a <= MSCR_PWM_LAST_ADDR);
  endfunction : is_chan_reg

  function automatic logic is_pwm_reg(input logic [7:0] a);
    return is_chan_reg(a) || ((a >= MSCR_GLB_FIRST_ADDR) && (a <= MSCR_GLB_LAST_ADDR));
  endfunction : is_pwm_reg

  function automatic logic [7:0] chan_slot(input logic [7:0] a);
    return 8'(a - MSCR_PWM_FIRST_ADDR);
  endfunction : chan_slot

  localparam logic [MSCR_OSC_CNT_W-1:0] OSC_LAST = MSCR_OSC_CNT_W'(OSC_START_CYCLES);
  localparam logic [MSCR_REGS_PER_CH-1:0] CH_FULL = '1;

  mscr_state_s s_reg;
  mscr_state_s s_next;

  logic [7:0] slot;
  logic       wr_mode_control_one;
  logic       wr_chan;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next            = s_reg;
    s_next.resume     = 1'b0;
    s_next.invalidate = 1'b0;
    slot              = chan_slot(s_reg.ptr);
    wr_mode_control_one          = i_acc.wr && (s_reg.ptr == MSCR_MODE_ONE_ADDR);
    wr_chan           = i_acc.wr && is_chan_reg(s_reg.ptr);

    if (i_acc.ptr_load) begin
      s_next.ptr = i_acc.wdata;
    end else if ((i_acc.wr || i_acc.rd) && s_reg.autoinc) begin
      s_next.ptr = s_reg.ptr + MSCR_PTR_STEP; // see [R1]
    end

    if (i_acc.rd) begin
      unique case (s_reg.ptr)
        MSCR_MODE_ONE_ADDR: s_next.rdata = {s_reg.restart, s_reg.external_clock_select, s_reg.autoinc,
                                            s_reg.sleep, s_reg.sub_en, s_reg.bcast_en};
        MSCR_MODE_TWO_ADDR: s_next.rdata = {MSCR_MODE_CONTROL_TWO_PAD, s_reg.mode_control_two};
        default:            s_next.rdata = MSCR_READ_ZERO;
      endcase
    end

    if (wr_mode_control_one) begin
      s_next.autoinc  = i_acc.wdata[MSCR_AUTOINC_BIT];
      s_next.sleep    = i_acc.wdata[MSCR_SLEEP_BIT]; // see [R2]
      s_next.sub_en   = i_acc.wdata[MSCR_SECONDARY_ADDR_ONE_ENABLE_BIT:MSCR_SECONDARY_ADDR_THREE_ENABLE_BIT]; // see [R3]
      s_next.bcast_en = i_acc.wdata[MSCR_BCAST_BIT]; // see [R4]
      // sticky: only set while already asleep and staying asleep
      if (s_reg.sleep && i_acc.wdata[MSCR_SLEEP_BIT] && i_acc.wdata[MSCR_EXTERNAL_CLOCK_SELECT_BIT]) begin
        s_next.external_clock_select = 1'b1;
      end
    end
    if (i_acc.wr && (s_reg.ptr == MSCR_MODE_TWO_ADDR)) begin
      s_next.mode_control_two = i_acc.wdata[4:0]; // see [R18]
    end

    // oscillator start-up, skipped on the external clock
    if (s_next.sleep) begin
      s_next.osc_cnt   = '0;
      s_next.osc_ready = 1'b0;
    end else if (s_reg.external_clock_select) begin
      s_next.osc_ready = 1'b1; // see [R6]
    end else if (!s_reg.osc_ready) begin
      s_next.osc_cnt = s_reg.osc_cnt + 1'b1;
      if (s_next.osc_cnt >= OSC_LAST) begin
        s_next.osc_ready = 1'b1; // see [R5]
      end
    end

    // channel write bookkeeping for the two update modes
    if (i_acc.wr && is_pwm_reg(s_reg.ptr)) begin
      s_next.pwm_dirty = 1'b1;
    end
    if (wr_chan) begin
      s_next.ch_mask[slot[5:0]] = 1'b1;
    end

    // restart clears: write 1 (only when awake and pending), stop, full channel
    if (wr_mode_control_one && i_acc.wdata[MSCR_RESTART_BIT] && !s_reg.sleep && s_reg.restart) begin
      s_next.restart = 1'b0; // see [R17] [R19]
      s_next.resume  = 1'b1; // see [R11]
    end
    if (i_bus_stop) begin
      s_next.pwm_dirty = i_acc.wr && is_pwm_reg(s_reg.ptr); // same-cycle write survives stop
      if (s_reg.pwm_dirty && !s_reg.mode_control_two[MSCR_OCH_BIT]) begin
        s_next.restart = 1'b0; // see [R13]
      end
    end
    if (wr_chan && s_reg.mode_control_two[MSCR_OCH_BIT] &&
        (s_next.ch_mask[{slot[5:2], 2'h0} +: MSCR_REGS_PER_CH] == CH_FULL)) begin
      s_next.restart = 1'b0; // see [R14]
      s_next.ch_mask[{slot[5:2], 2'h0} +: MSCR_REGS_PER_CH] = '0;
    end

    // restart sequencer
    unique case (s_reg.rs)
      MSCR_RS_RUN: begin
        if (s_next.sleep) begin
          if (i_channels_active) begin
            s_next.rs = MSCR_RS_DRAIN;
          end else begin
            s_next.rs         = MSCR_RS_SLEEP;
            s_next.restart    = 1'b0; // see [R15]
            s_next.invalidate = 1'b1; // see [R15]
          end
        end
      end
      MSCR_RS_DRAIN: begin
        if (i_period_end) begin
          s_next.rs      = MSCR_RS_SLEEP;
          s_next.restart = 1'b1; // set beats a same-cycle write, stop or channel clear, but not software reset; see [R8]
        end
      end
      MSCR_RS_SLEEP: begin
        if (!s_next.sleep) begin
          s_next.rs = s_next.restart ? MSCR_RS_WAKE : MSCR_RS_RUN;
        end
      end
      MSCR_RS_WAKE: begin
        if (s_next.sleep) begin
          s_next.rs = MSCR_RS_SLEEP;
        end else if (!s_next.restart) begin
          s_next.rs = MSCR_RS_RUN; // resumed or reloaded
        end
      end
    endcase

    // drain keeps the current period going; otherwise oscillator must be up
    s_next.pwm_run = (s_next.rs == MSCR_RS_DRAIN) ||
                     ((s_next.rs == MSCR_RS_RUN) && s_next.osc_ready); // see [R7]
    s_next.hold    = (s_next.rs == MSCR_RS_SLEEP) || (s_next.rs == MSCR_RS_WAKE); // see [R9]

    if (i_soft_reset) begin
      s_next          = '0;
      s_next.sleep    = MSCR_SLEEP_RESET;
      s_next.bcast_en = MSCR_BCAST_RESET;
      s_next.mode_control_two    = MSCR_MODE_CONTROL_TWO_RESET;
      s_next.rs       = MSCR_RS_SLEEP;
      s_next.hold     = 1'b1; // see [R12]
    end
    s_next.osc_en = !s_next.sleep; // see [R2]
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_reg          <= '0; // restart flag, auto-increment clear; see [R12]
      s_reg.sleep    <= MSCR_SLEEP_RESET;
      s_reg.sub_en   <= MSCR_SUB_RESET;
      s_reg.bcast_en <= MSCR_BCAST_RESET;
      s_reg.mode_control_two    <= MSCR_MODE_CONTROL_TWO_RESET;
      s_reg.rs       <= MSCR_RS_SLEEP;
      s_reg.hold     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pointer          = s_reg.ptr;
  assign o_rdata            = s_reg.rdata;
  assign o_sub_enable       = s_reg.sub_en;
  assign o_broadcast_enable = s_reg.bcast_en;
  assign o_osc_enable       = s_reg.osc_en;
  assign o_osc_ready        = s_reg.osc_ready;
  assign o_pwm_run          = s_reg.pwm_run;
  assign o_channel_hold     = s_reg.hold;
  assign o_apply_on_ack     = s_reg.mode_control_two[MSCR_OCH_BIT];
  assign o_resume           = s_reg.resume;
  assign o_invalidate       = s_reg.invalidate;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_sleep_active;
    s_reg.rs == MSCR_RS_RUN && s_next.sleep && i_channels_active && !i_soft_reset;
  endsequence
  sequence s_period_done;
    s_reg.rs == MSCR_RS_DRAIN && i_period_end && !i_soft_reset;
  endsequence

  a_ptr_advance: assert property ( // see [R1]
    (i_acc.rd && !i_acc.ptr_load && !i_soft_reset) |=>
      s_reg.ptr == ($past(s_reg.ptr) + ($past(s_reg.autoinc) ? MSCR_PTR_STEP : 8'h00)))
    else $error("pointer step wrong");
  a_sleep_write: assert property ( // see [R2]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && !i_acc.wdata[MSCR_SLEEP_BIT]
     && !i_soft_reset) |=> !s_reg.sleep ##1 o_osc_enable)
    else $error("sleep clear ignored");
  a_sub_follow: assert property ( // see [R3]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && !i_soft_reset) |=>
      o_sub_enable == $past(i_acc.wdata[MSCR_SECONDARY_ADDR_ONE_ENABLE_BIT:MSCR_SECONDARY_ADDR_THREE_ENABLE_BIT]))
    else $error("secondary enables wrong");
  a_bcast_follow: assert property ( // see [R4]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && !i_soft_reset) |=>
      o_broadcast_enable == $past(i_acc.wdata[MSCR_BCAST_BIT]))
    else $error("broadcast enable wrong");
  a_osc_wait: assert property ( // see [R5]
    ($fell(s_reg.sleep) && !s_reg.external_clock_select) |-> !o_osc_ready [*8])
    else $error("oscillator ready too early");
  a_ext_nowait: assert property ( // see [R6]
    ($fell(s_reg.sleep) && s_reg.external_clock_select && !i_soft_reset) |=> o_osc_ready)
    else $error("external clock waited");
  a_sleep_quiet: assert property ( // see [R7]
    (s_reg.rs == MSCR_RS_SLEEP) |-> !o_pwm_run)
    else $error("pwm running in sleep");
  a_restart_set: assert property ( // see [R8]
    s_sleep_active ##1 (!i_period_end && !i_soft_reset) [*2] ##1 s_period_done |=>
      s_reg.restart && o_channel_hold)
    else $error("restart flag not set");
  a_resume_pulse: assert property ( // see [R11]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && i_acc.wdata[MSCR_RESTART_BIT]
     && !s_reg.sleep && s_reg.restart && !i_soft_reset) |=> o_resume && !s_reg.restart)
    else $error("resume missing");
  a_swreset_clr: assert property ( // see [R12]
    i_soft_reset |=> !s_reg.restart && s_reg.sleep && !s_reg.external_clock_select)
    else $error("software reset incomplete");
  a_orderly_off: assert property ( // see [R15]
    (s_reg.rs == MSCR_RS_RUN && s_next.sleep && !i_channels_active && !i_soft_reset)
      |=> o_invalidate && !s_reg.restart ##1 !o_invalidate)
    else $error("orderly shutdown handling wrong");
  a_restart_guard: assert property ( // see [R19]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && s_reg.sleep) |=> !o_resume)
    else $error("resume while asleep");
  a_stop_clear: assert property ( // see [R13]
    (i_bus_stop && s_reg.pwm_dirty && !s_reg.mode_control_two[MSCR_OCH_BIT] && !i_period_end
     && !i_soft_reset) |=> !s_reg.restart)
    else $error("stop did not clear restart");
  a_flag_keep: assert property ( // see [R17]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_ONE_ADDR && !i_acc.wdata[MSCR_RESTART_BIT]
     && !i_bus_stop && !i_period_end && !i_soft_reset) |=>
      s_reg.restart == $past(s_reg.restart))
    else $error("restart changed by zero write");
  a_och_follow: assert property ( // see [R18]
    (i_acc.wr && s_reg.ptr == MSCR_MODE_TWO_ADDR && !i_soft_reset) |=>
      o_apply_on_ack == $past(i_acc.wdata[MSCR_OCH_BIT]))
    else $error("output-change setting wrong");
  a_hold_sleep: assert property ( // see [R9]
    (s_reg.rs == MSCR_RS_SLEEP) |-> o_channel_hold)
    else $error("channels not held in sleep");

endmodule : mscr_mode_ctrl

`default_nettype wire

// file: dv/mscr_host_model.sv
// host-side model: register accesses, bus stop and the restart order
`timescale 1ns/100ps
`default_nettype none

module mscr_host_model
  import mscr_pkg::*;
(
  input  wire logic       i_clock,
  output var  mscr_acc_s  o_acc,
  output var  logic       o_bus_stop
);
  // idle cycles before each access; the bench varies it to act slow
  int gap = 0;

  initial begin
    o_acc = '0;
    o_bus_stop = 1'b0;
  end

  // one-cycle access, changed only at falling edges
  task automatic op(input mscr_acc_s a);
    repeat (gap) @(negedge i_clock);
    @(negedge i_clock);
    o_acc = a;
    @(negedge i_clock);
    o_acc = '0;
  endtask : op

  task automatic wr_at(input logic [7:0] adr, input logic [7:0] d);
    op({3'h4, adr});
    op({3'h2, d});
  endtask : wr_at

  task automatic rd_at(input logic [7:0] adr);
    op({3'h4, adr});
    op({3'h1, 8'h00});
  endtask : rd_at

  task automatic stop_pulse;
    @(negedge i_clock);
    o_bus_stop = 1'b1;
    @(negedge i_clock);
    o_bus_stop = 1'b0;
  endtask : stop_pulse

  // read flag, wake, sit out oscillator start-up, then restart
  task automatic restart_seq(input int wait_cycles);
    rd_at(MSCR_MODE_ONE_ADDR);
    wr_at(MSCR_MODE_ONE_ADDR, 8'h01);
    repeat (wait_cycles) @(negedge i_clock);
    wr_at(MSCR_MODE_ONE_ADDR, 8'h81);
  endtask : restart_seq

  // contents are void after orderly shutdown, so all four go again
  task automatic reload(input logic [7:0] first);
    for (int k = 0; k < 4; k++) begin
      wr_at(first + k[7:0], 8'h00);
    end
  endtask : reload
endmodule : mscr_host_model

`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the mode, sleep and restart control block
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import mscr_pkg::*;
;
  // short start-up count keeps the run brief
  localparam int OSC = 16;
  logic       i_clock = 1'b0;
  logic       i_reset_n = 1'b0;
  mscr_acc_s  i_acc;
  logic       i_bus_stop;
  logic       i_soft_reset = 1'b0;
  logic       i_period_end = 1'b0;
  logic       i_channels_active = 1'b0;
  logic [7:0] o_pointer, o_rdata;
  logic [2:0] o_sub_enable;
  logic       o_broadcast_enable, o_osc_enable, o_osc_ready, o_pwm_run;
  logic       o_channel_hold, o_apply_on_ack, o_resume, o_invalidate;
  logic       rd_seen = 1'b0;
  logic       inval_seen = 1'b0;
  int         n_fail = 0;
  int         total_checks = 0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000005D;

  mscr_mode_ctrl #(.OSC_START_CYCLES(OSC)) dut (
    .i_clock, .i_reset_n, .i_acc, .i_bus_stop, .i_soft_reset, .i_period_end,
    .i_channels_active, .o_pointer, .o_rdata, .o_sub_enable, .o_broadcast_enable,
    .o_osc_enable, .o_osc_ready, .o_pwm_run, .o_channel_hold, .o_apply_on_ack,
    .o_resume, .o_invalidate
  );
  mscr_host_model u_host (.i_clock(i_clock), .o_acc(i_acc), .o_bus_stop(i_bus_stop));

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd_at(a);
  endtask : rd_exp

  task automatic soft_pulse;
    @(negedge i_clock);
    i_soft_reset = 1'b1;
    @(negedge i_clock);
    i_soft_reset = 1'b0;
  endtask : soft_pulse

  task automatic pe_pulse;
    @(negedge i_clock);
    i_period_end = 1'b1;
    @(negedge i_clock);
    i_period_end = 1'b0;
    @(negedge i_clock);
  endtask : pe_pulse

  // wake, then sleep with channels live so the flag gets set
  task automatic set_flag;
    i_channels_active = 1'b1;
    u_host.wr_at(8'h00, 8'h01);
    repeat (OSC + 4) @(negedge i_clock);
    u_host.wr_at(8'h00, 8'h11);
    chk(o_pwm_run, 1'b1);
    // period ends a few cycles into the drain, not at once
    @(negedge i_clock);
    pe_pulse;
    chk(o_channel_hold, 1'b1);
    chk(o_pwm_run, 1'b0);
  endtask : set_flag

  // read data lands one cycle after the read strobe
  always @(posedge i_clock) rd_seen <= i_acc.rd;
  always @(posedge i_clock) if (o_invalidate === 1'b1) inval_seen <= 1'b1;
  always @(negedge i_clock) begin
    if (rd_seen && exp_q.size() > 0) chk(o_rdata, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    chk(o_sub_enable, 3'h0);
    chk(o_broadcast_enable, 1'b1);
    chk(o_osc_enable, 1'b0);
    chk(o_apply_on_ack, 1'b0);
    rd_exp(8'h00, 8'h11);
    rd_exp(8'h01, 8'h04);
    u_host.wr_at(8'h00, 8'h31);
    rd_exp(8'h00, 8'h31);
    chk(o_pointer, 8'h01);
    u_host.wr_at(8'h00, 8'h11);
    rd_exp(8'h00, 8'h11);
    chk(o_pointer, 8'h00);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      u_host.gap = int'(seed[9:8]);
      u_host.wr_at(8'h00, {4'h1, seed[3:0]});
      chk(o_sub_enable, seed[3:1]);
      chk(o_broadcast_enable, seed[0]);
    end
    u_host.gap = 0;
    u_host.wr_at(8'h00, 8'h01);
    @(negedge i_clock);
    chk(o_osc_enable, 1'b1);
    chk(o_osc_ready, 1'b0);
    repeat (OSC + 4) @(negedge i_clock);
    chk(o_osc_ready, 1'b1);
    // external clock: ready with no start-up wait
    soft_pulse;
    u_host.wr_at(8'h00, 8'h51);
    u_host.wr_at(8'h00, 8'h41);
    repeat (3) @(negedge i_clock);
    chk(o_osc_ready, 1'b1);
    rd_exp(8'h00, 8'h41);
    // restart refused while asleep, then accepted
    soft_pulse;
    set_flag;
    u_host.wr_at(8'h00, 8'h91);
    chk(o_resume, 1'b0);
    exp_q.push_back(8'h91);
    u_host.restart_seq(OSC + 4);
    chk(o_resume, 1'b1);
    @(negedge i_clock);
    chk(o_channel_hold, 1'b0);
    rd_exp(8'h00, 8'h01);
    // awake but nothing pending: no resume
    u_host.wr_at(8'h00, 8'h81);
    chk(o_resume, 1'b0);
    // flag cleared by a pwm write and a stop
    soft_pulse;
    set_flag;
    u_host.wr_at(8'h00, 8'h01);
    rd_exp(8'h00, 8'h81);
    u_host.wr_at(8'h06, 8'h3C);
    rd_exp(8'h00, 8'h81);
    u_host.stop_pulse;
    rd_exp(8'h00, 8'h01);
    // change on acknowledge: all four registers of one channel
    soft_pulse;
    u_host.wr_at(8'h01, 8'h0C);
    chk(o_apply_on_ack, 1'b1);
    set_flag;
    u_host.wr_at(8'h00, 8'h01);
    for (int k = 0; k < 4; k++) begin
      rd_exp(8'h00, 8'h81);
      u_host.wr_at(8'h0A + k[7:0], 8'h00);
    end
    rd_exp(8'h00, 8'h01);
    // software reset drops a pending flag
    soft_pulse;
    set_flag;
    soft_pulse;
    rd_exp(8'h00, 8'h11);
    // orderly shutdown: no flag, contents void
    i_channels_active = 1'b0;
    u_host.wr_at(8'h00, 8'h01);
    repeat (OSC + 4) @(negedge i_clock);
    chk(inval_seen, 1'b0);
    u_host.wr_at(8'h00, 8'h11);
    repeat (3) @(negedge i_clock);
    chk(inval_seen, 1'b1);
    pe_pulse;
    rd_exp(8'h00, 8'h11);
    u_host.reload(8'h06);
    repeat (2) @(negedge i_clock);
    chk(8'(exp_q.size()), 8'h00);
    final_report;
  end

  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    #(20000 * 100);
    n_fail++;
    final_report;
  end
endmodule : tb_top

`default_nettype wire
